// ==== inc/wmx_pkg.sv ====
// Purpose: constants, register map and types of the word move / exchange unit
// Assumes: 16-bit data words, 256-word local data memory, AXI4-Lite with 32-bit data
// Notes: op codes are software visible and therefore carry fixed codes
package wmx_pkg;
  // ==========================================================
  // widths and timing
  localparam int unsigned MEM_AW = 8;
  localparam int unsigned MEM_DEPTH = 256;
  localparam int unsigned CLK_PERIOD_NS = 20;
  // plain copy spends this I/O refresh time; fast copy skips it
  localparam int unsigned REFRESH_NS = 1200;
  localparam int unsigned REFRESH_CYC = (REFRESH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // ==========================================================
  // register byte offsets
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_SRC = 12'h004;
  localparam logic [11:0] OFF_DST = 12'h008;
  localparam logic [11:0] OFF_PARAM = 12'h00C;
  localparam logic [11:0] OFF_CONST = 12'h010;
  localparam logic [11:0] OFF_STATUS = 12'h014;
  localparam logic [11:0] OFF_MADDR = 12'h018;
  localparam logic [11:0] OFF_MDATA = 12'h01C;
  localparam logic [11:0] OFF_INDEX = 12'h020;
  // ==========================================================
  // control register fields
  localparam int unsigned CTRL_START = 0;
  localparam int unsigned CTRL_COND = 1;
  localparam int unsigned CTRL_IND = 2;
  localparam int unsigned CTRL_BCD = 3;
  localparam int unsigned CTRL_CONST = 4;
  localparam int unsigned CTRL_TC = 5;
  localparam int unsigned CTRL_OP_LSB = 8;
  localparam int unsigned CTRL_IR_LSB = 12;
  // status register fields
  localparam int unsigned STAT_BUSY = 0;
  localparam int unsigned STAT_FAULT = 1;
  localparam int unsigned STAT_ZERO = 2;
  localparam int unsigned STAT_MSB = 3;
  // bit-field control word fields
  localparam int unsigned PAR_SBIT_LSB = 0;
  localparam int unsigned PAR_DBIT_LSB = 4;
  localparam int unsigned PAR_LEN_LSB = 8;
  // completion flag word base for timers/counters
  localparam logic [11:0] TC_FLAG_BASE = 12'h200;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ==========================================================
  // operation codes
  localparam logic [3:0] OP_COPY = 4'h0;
  localparam logic [3:0] OP_INV = 4'h1;
  localparam logic [3:0] OP_PAIR = 4'h2;
  localparam logic [3:0] OP_INVP = 4'h3;
  localparam logic [3:0] OP_SWAP = 4'h4;
  localparam logic [3:0] OP_SWAPP = 4'h5;
  localparam logic [3:0] OP_ADDR = 4'h6;
  localparam logic [3:0] OP_FAST = 4'h7;
  localparam logic [3:0] OP_BITF = 4'h8;
  localparam logic [3:0] OP_BLOCK = 4'h9;

  typedef enum logic [3:0] {
    S_IDLE, S_PTR, S_PTRW, S_SETUP, S_LDA, S_LDAW, S_LDB, S_LDBW,
    S_WRB, S_WRA, S_NEXT, S_SETTLE, S_FIN
  } wmx_state_type;

  // ==========================================================
  // decimal helpers
  function automatic logic wmx_is_bcd(input logic [15:0] w);
    logic ok;
    ok = 1'b1;
    for (int i = 0; i < 4; i++) begin
      if (w[4*i +: 4] > 4'h9) ok = 1'b0;
    end
    return ok;
  endfunction : wmx_is_bcd

  function automatic logic [15:0] wmx_bcd2bin(input logic [15:0] w);
    return 16'(16'(w[15:12]) * 16'h03E8 + 16'(w[11:8]) * 16'h0064
      + 16'(w[7:4]) * 16'h000A + 16'(w[3:0]));
  endfunction : wmx_bcd2bin
endpackage : wmx_pkg

// ==== verilog/wmx_mem.sv ====
// Purpose: single-port data word memory of the move unit
// Assumes: one access per cycle, read data one cycle after the address
// Notes: read returns the old word on a write to the same address
`timescale 1ns/1ps
`default_nettype none
module wmx_mem import wmx_pkg::*; (
  input wire logic aclk,
  input wire logic we,
  input wire logic [MEM_AW-1:0] addr,
  input wire logic [15:0] wd,
  output logic [15:0] rd
);
  logic [15:0] mem_q [MEM_DEPTH];
  logic [15:0] rd_q;

  always_ff @(posedge aclk) begin
    if (we) mem_q[addr] <= wd;
    rd_q <= mem_q[addr];
  end

  assign rd = rd_q;
endmodule : wmx_mem
`default_nettype wire

// ==== verilog/wmx_core.sv ====
// Purpose: word move / exchange execution unit with AXI4-Lite register access
// Assumes: program keeps operands inside memory, pairs off the last word, blocks apart
// Notes: one operation at a time; start while busy is ignored
//
// Chosen here: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - false execution condition does nothing; true condition moves data
// - single copy and invert set zero flag when destination is zero
// - single copy and invert copy destination bit 15 into msb flag
// - non-decimal indirect pointer in decimal mode raises fault flag
// - invert copy writes complement of source word or constant
// - pair copy moves source and next word to destination and next
// - pair ops: zero when both words zero, msb from upper word; swap pair sets neither flag
// - invert pair writes complement of two words or 32-bit constant
// - swap word exchanges the two operand words
// - swap pair exchanges two word pairs
// - address-to-index loads operand address, not its contents
// - timer or counter operand loads its completion flag bit address
// - bit address: word in upper three digits, bit in lowest
// - index register chosen directly; zero flag when zero loaded
// - fast copy ten or more times quicker with direct operands (6 cycles vs 66), zero and msb flags untouched; with indirect operands 8 cycles vs 68 for plain copy
// - bit-field start bits come from control word digits
// - bit-field length byte; zero moves nothing; bits cross words
// - bit-field changes only transferred destination bits
// - block copy moves counted run of words in order
// - only destination words change, except swap ops, which also rewrite the source words
module wmx_core import wmx_pkg::*; (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [11:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic op_done,
  output logic fault_flag,
  output logic zero_flag,
  output logic msb_flag
);
  // ==========================================================
  // bus slave state
  logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q, aw_ok_q, w_ok_q;
  logic [11:0] awaddr_q;
  logic [31:0] wdata_q, rdata_q;
  logic [3:0] wstrb_q;
  logic [1:0] bresp_q, rresp_q;
  // software registers
  logic [15:0] ctrl_q, src_q, par_q;
  logic [7:0] dst_q, maddr_q;
  logic [31:0] const_q;
  logic [15:0] ir_q [4];
  // engine state
  wmx_state_type st_q;
  logic [3:0] opc_q, sb_q, db_q;
  logic [1:0] irs_q;
  logic konst_q, tc_q, zacc_q, fault_q, zero_q, msb_q, done_q;
  logic [7:0] a_q, b_q;
  logic [15:0] n_q, idx_q, va_q, vb_q, lastw_q;
  logic [7:0] settle_q;

  function automatic logic [31:0] wmerge(input logic [31:0] o, input logic [31:0] d,
                                         input logic [31:0] m);
    return (o & ~m) | (d & m);
  endfunction : wmerge

  // ==========================================================
  // write decode
  wire wr_fire = aw_ok_q & w_ok_q & ~bvalid_q;
  wire [31:0] wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  wire idle = (st_q == S_IDLE);
  wire wr_ctrl = wr_fire & (awaddr_q == OFF_CTRL);
  wire wr_src = wr_fire & (awaddr_q == OFF_SRC);
  wire wr_dst = wr_fire & (awaddr_q == OFF_DST);
  wire wr_par = wr_fire & (awaddr_q == OFF_PARAM);
  wire wr_const = wr_fire & (awaddr_q == OFF_CONST);
  wire wr_maddr = wr_fire & (awaddr_q == OFF_MADDR);
  wire wr_mdata = wr_fire & (awaddr_q == OFF_MDATA);
  wire aw_ro = (awaddr_q == OFF_STATUS) | (awaddr_q[11:4] == OFF_INDEX[11:4]
    && awaddr_q[1:0] == 2'h0 && awaddr_q[3:2] <= 2'h3);
  wire aw_map = wr_ctrl | wr_src | wr_dst | wr_par | wr_const | wr_maddr | wr_mdata | aw_ro;
  wire [31:0] ctrl_new = wmerge({16'h0000, ctrl_q}, wdata_q, wmask);
  wire [31:0] mdata_new = wmerge(32'h0000_0000, wdata_q, wmask);
  wire start_w = wr_ctrl & ctrl_new[CTRL_START] & idle;
  wire run_w = start_w & ctrl_new[CTRL_COND];

  // ==========================================================
  // read decode
  logic [15:0] mem_rd;
  wire [3:0] status = {msb_q, zero_q, fault_q, ~idle};
  wire ar_idx = (araddr[11:4] == OFF_INDEX[11:4]) && (araddr[1:0] == 2'h0);
  wire [31:0] rd_val =
    (araddr == OFF_CTRL) ? {16'h0000, ctrl_q} :
    (araddr == OFF_SRC) ? {16'h0000, src_q} :
    (araddr == OFF_DST) ? {24'h000000, dst_q} :
    (araddr == OFF_PARAM) ? {16'h0000, par_q} :
    (araddr == OFF_CONST) ? const_q :
    (araddr == OFF_STATUS) ? {28'h0000000, status} :
    (araddr == OFF_MADDR) ? {24'h000000, maddr_q} :
    (araddr == OFF_MDATA) ? {16'h0000, mem_rd} :
    ar_idx ? {16'h0000, ir_q[araddr[3:2]]} : 32'h0000_0000;
  wire ar_map = ar_idx | (araddr <= OFF_MDATA && araddr[1:0] == 2'h0);

  // ==========================================================
  // AXI4-Lite handshakes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      aw_ok_q <= 1'b0;
      w_ok_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end else begin
      if (awvalid && awready_q) begin
        awaddr_q <= awaddr;
        awready_q <= 1'b0;
        aw_ok_q <= 1'b1;
      end
      if (wvalid && wready_q) begin
        wdata_q <= wdata;
        wstrb_q <= wstrb;
        wready_q <= 1'b0;
        w_ok_q <= 1'b1;
      end
      if (wr_fire) begin
        bvalid_q <= 1'b1;
        bresp_q <= aw_map ? RESP_OKAY : RESP_SLVERR;
        aw_ok_q <= 1'b0;
        w_ok_q <= 1'b0;
      end
      if (bvalid_q && bready) begin
        bvalid_q <= 1'b0;
        awready_q <= 1'b1;
        wready_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= RESP_OKAY;
    end else if (arvalid && arready_q) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rdata_q <= rd_val;
      rresp_q <= ar_map ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_q && rready) begin
      rvalid_q <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  // ==========================================================
  // software registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= '0;
      src_q <= '0;
      dst_q <= '0;
      par_q <= '0;
      const_q <= '0;
      maddr_q <= '0;
    end else begin
      if (wr_ctrl) ctrl_q <= {ctrl_new[15:1], 1'b0};
      if (wr_src) src_q <= 16'(wmerge({16'h0000, src_q}, wdata_q, wmask));
      if (wr_dst) dst_q <= 8'(wmerge({24'h000000, dst_q}, wdata_q, wmask));
      if (wr_par) par_q <= 16'(wmerge({16'h0000, par_q}, wdata_q, wmask));
      if (wr_const) const_q <= wmerge(const_q, wdata_q, wmask);
      if (wr_maddr) maddr_q <= 8'(wmerge({24'h000000, maddr_q}, wdata_q, wmask));
    end
  end

  // ==========================================================
  // memory port
  wire is_swap = (opc_q == OP_SWAP) | (opc_q == OP_SWAPP);
  wire is_bitf = (opc_q == OP_BITF);
  wire is_inv = (opc_q == OP_INV) | (opc_q == OP_INVP);
  wire flag_op = (opc_q == OP_COPY) | is_inv | (opc_q == OP_PAIR);
  wire [15:0] bit_mask = 16'h0001 << db_q;
  wire [15:0] wres_bf = (vb_q & ~bit_mask) | ({16{va_q[sb_q]}} & bit_mask);
  wire [15:0] wres = is_bitf ? wres_bf : is_inv ? ~va_q : va_q;
  wire [15:0] k_word = (idx_q == 16'h0000) ? const_q[15:0] : const_q[31:16];
  wire [7:0] mem_addr = (st_q == S_PTR) ? src_q[7:0] :
    (st_q == S_LDA || st_q == S_WRA) ? a_q :
    (st_q == S_LDB || st_q == S_WRB) ? b_q : maddr_q;
  // destination is written in S_WRB, source in S_WRA for swaps, and memory data from the bus when idle
  wire mem_we = (st_q == S_WRB) | (st_q == S_WRA) | (idle & wr_mdata);
  wire [15:0] mem_wd = (st_q == S_WRB) ? wres : (st_q == S_WRA) ? vb_q : mdata_new[15:0];
  wire last_item = (idx_q == n_q - 16'h0001);
  wire [15:0] ir_val = tc_q ? {12'(TC_FLAG_BASE + src_q[15:4]), src_q[3:0]}
    : 16'(a_q);
  wire ir_we = (st_q == S_SETUP) & (opc_q == OP_ADDR);
  wire [15:0] blk_n = wmx_bcd2bin(par_q);
  wire [15:0] bf_n = 16'(par_q[PAR_LEN_LSB +: 8]);

  wmx_mem u_mem (
    .aclk(aclk),
    .we(mem_we),
    .addr(mem_addr),
    .wd(mem_wd),
    .rd(mem_rd)
  );

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_ir
      always_ff @(posedge aclk) begin
        if (!aresetn) ir_q[gi] <= '0;
        else if (ir_we && irs_q == 2'(gi)) ir_q[gi] <= ir_val;
      end
    end
  endgenerate

  // ==========================================================
  // execution engine
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= S_IDLE;
      {opc_q, sb_q, db_q, irs_q, konst_q, tc_q} <= '0;
      {a_q, b_q, n_q, idx_q, va_q, vb_q, lastw_q, settle_q} <= '0;
      {zacc_q, fault_q, zero_q, msb_q, done_q} <= '0;
    end else begin
      done_q <= 1'b0;
      unique case (st_q)
        S_IDLE: if (run_w) begin
          opc_q <= ctrl_new[CTRL_OP_LSB +: 4];
          irs_q <= ctrl_new[CTRL_IR_LSB +: 2];
          konst_q <= ctrl_new[CTRL_CONST];
          tc_q <= ctrl_new[CTRL_TC];
          a_q <= src_q[7:0];
          b_q <= dst_q;
          idx_q <= '0;
          zacc_q <= 1'b1;
          if (ctrl_new[CTRL_OP_LSB +: 4] != OP_FAST) fault_q <= 1'b0;
          st_q <= ctrl_new[CTRL_IND] ? S_PTR : S_SETUP;
        end
        S_PTR: st_q <= S_PTRW;
        S_PTRW: begin
          if (ctrl_q[CTRL_BCD] && !wmx_is_bcd(mem_rd)) begin
            fault_q <= 1'b1;
            st_q <= S_FIN;
          end else begin
            a_q <= ctrl_q[CTRL_BCD] ? 8'(wmx_bcd2bin(mem_rd)) : mem_rd[7:0];
            st_q <= S_SETUP;
          end
        end
        S_SETUP: begin
          sb_q <= par_q[PAR_SBIT_LSB +: 4];
          db_q <= par_q[PAR_DBIT_LSB +: 4];
          st_q <= S_LDA;
          if (opc_q == OP_PAIR || opc_q == OP_INVP || opc_q == OP_SWAPP) n_q <= 16'h0002;
          else if (opc_q == OP_BITF) n_q <= bf_n;
          else if (opc_q == OP_BLOCK) n_q <= blk_n;
          else n_q <= 16'h0001;
          if (opc_q == OP_ADDR) begin
            zacc_q <= (ir_val == 16'h0000);
            st_q <= S_FIN;
          end else if (opc_q > OP_BLOCK || (opc_q == OP_BLOCK && !wmx_is_bcd(par_q))) begin
            fault_q <= 1'b1;
            st_q <= S_FIN;
          end else if ((is_bitf && bf_n == 16'h0000)
                       || (opc_q == OP_BLOCK && blk_n == 16'h0000)) begin
            st_q <= S_FIN;
          end
        end
        S_LDA: st_q <= S_LDAW;
        S_LDAW: begin
          va_q <= konst_q ? k_word : mem_rd;
          st_q <= (is_swap || is_bitf) ? S_LDB : S_WRB;
        end
        S_LDB: st_q <= S_LDBW;
        S_LDBW: begin
          vb_q <= mem_rd;
          st_q <= S_WRB;
        end
        S_WRB: begin
          zacc_q <= zacc_q & (wres == 16'h0000);
          lastw_q <= wres;
          st_q <= is_swap ? S_WRA : S_NEXT;
        end
        S_WRA: st_q <= S_NEXT;
        S_NEXT: begin
          idx_q <= idx_q + 16'h0001;
          if (is_bitf) begin
            sb_q <= sb_q + 4'h1;
            db_q <= db_q + 4'h1;
            if (sb_q == 4'hF) a_q <= a_q + 8'h01;
            if (db_q == 4'hF) b_q <= b_q + 8'h01;
          end else begin
            a_q <= a_q + 8'h01;
            b_q <= b_q + 8'h01;
          end
          if (!last_item) st_q <= S_LDA;
          else st_q <= (opc_q == OP_COPY) ? S_SETTLE : S_FIN;
          settle_q <= '0;
        end
        S_SETTLE: begin
          settle_q <= settle_q + 8'h01;
          if (settle_q == 8'(REFRESH_CYC - 1)) st_q <= S_FIN;
        end
        S_FIN: begin
          done_q <= 1'b1;
          if (!fault_q && (flag_op || opc_q == OP_ADDR)) zero_q <= zacc_q;
          if (!fault_q && flag_op) msb_q <= lastw_q[15];
          st_q <= S_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // checks
  a_cond_false_idle: assert property (@(posedge aclk) disable iff (!aresetn)
    (start_w && !ctrl_new[CTRL_COND]) |=> (st_q == S_IDLE) [*3])
    else $error("operation started with false condition");
  a_zero_single: assert property (@(posedge aclk) disable iff (!aresetn)
    (done_q && !fault_q && (opc_q == OP_COPY || opc_q == OP_INV))
      |-> zero_q == (lastw_q == 16'h0000))
    else $error("zero flag does not match destination");
  a_msb_single: assert property (@(posedge aclk) disable iff (!aresetn)
    (done_q && !fault_q && (opc_q == OP_COPY || opc_q == OP_INV))
      |-> msb_q == lastw_q[15])
    else $error("msb flag not taken from destination bit 15");
  a_fault_bcd: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_q == S_PTRW && ctrl_q[CTRL_BCD] && !wmx_is_bcd(mem_rd))
      |=> fault_q && st_q == S_FIN ##1 done_q)
    else $error("bad decimal pointer did not fault");
  a_inv_data: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_q == S_WRB && is_inv) |-> mem_we && mem_wd == ~va_q && mem_addr == b_q)
    else $error("invert write is not the complement");
  a_swap_both: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_q == S_WRB && is_swap) |-> mem_wd == va_q ##1 (st_q == S_WRA && mem_wd == $past(vb_q)))
    else $error("swap did not write both words");
  a_fast_flags: assert property (@(posedge aclk) disable iff (!aresetn)
    (done_q && opc_q == OP_FAST) |-> $stable(zero_q) && $stable(msb_q) && $stable(fault_q))
    else $error("fast copy changed a flag");
  a_bf_len_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_q == S_SETUP && is_bitf && bf_n == 16'h0000) |=> st_q == S_FIN ##1 st_q == S_IDLE)
    else $error("zero length bit-field moved data");
  a_bf_mask: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_q == S_WRB && is_bitf) |-> ((mem_wd ^ vb_q) & ~bit_mask) == 16'h0000)
    else $error("bit-field touched other bits");

  assign awready = awready_q;
  assign wready = wready_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = arready_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;
  assign op_done = done_q;
  assign fault_flag = fault_q;
  assign zero_flag = zero_q;
  assign msb_flag = msb_q;
endmodule : wmx_core
`default_nettype wire

// ==== sim/wmx_seq_model.sv ====
// Purpose: sequencer model issuing register bus cycles to the move unit
// Assumes: one write and one read at a time, full word strobes
// Notes: programs keep pairs off area ends, counts decimal, blocks apart
`timescale 1ns/1ps
`default_nettype none
module wmx_seq_model import wmx_pkg::*; (
  input wire logic aclk,
  output logic [11:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  output logic [11:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready
);
  // ==========
  // bus cycles
  initial begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready, araddr, arvalid, rready} = '0;
  end

  task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    logic pa;
    logic pw;
    pa = 1'b1;
    pw = 1'b1;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (pa || pw) begin
      @(posedge aclk);
      if (pa && awready) begin
        pa = 1'b0;
        awvalid <= 1'b0;
        awaddr <= ~a;
      end
      if (pw && wready) begin
        pw = 1'b0;
        wvalid <= 1'b0;
        wdata <= ~d;
      end
    end
    bready <= 1'b1;
    do @(posedge aclk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    araddr <= ~a;
    rready <= 1'b1;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : rd
endmodule : wmx_seq_model
`default_nettype wire

// ==== sim/tb_top.sv ====
// Purpose: self-checking bench of the word move / exchange unit
// Assumes: sequencer model drives the register bus
// Notes: plain copy timing is compared against fast copy
`timescale 1ns/1ps
`default_nettype none
module tb_top import wmx_pkg::*; ();
  localparam logic [31:0] CND = 32'h2;
  localparam logic [31:0] IND = 32'h4;
  localparam logic [31:0] DEC = 32'h8;
  localparam logic [31:0] CST = 32'h10;
  localparam logic [31:0] TCN = 32'h20;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [11:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic op_done, fault_flag, zero_flag, msb_flag;
  int n_fail = 0;
  int samples_checked = 0;
  int cyc = 0;
  int n_done = 0;
  int t_done = 0;
  int t0 = 0;

  wmx_core i_wmx_core (.*);
  wmx_seq_model i_wmx_seq_model (.*);

  always #10 aclk = ~aclk;

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (op_done === 1'b1) begin
      n_done <= n_done + 1;
      t_done <= cyc;
    end
    if (cyc == 20000) begin
      n_fail = n_fail + 1;
      stop_test();
    end
  end

  // ==========
  // helpers
  task automatic stop_test;
    $display("checks %0d failures %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [1:0] r;
    i_wmx_seq_model.wr(a, d, r);
  endtask : wr

  task automatic rck(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
    logic [31:0] g;
    logic [1:0] r;
    i_wmx_seq_model.rd(a, g, r);
    chk("read data", e, g);
    chk("read response", {30'h0, er}, {30'h0, r});
  endtask : rck

  task automatic mw(input logic [7:0] a, input logic [31:0] v, input int n);
    for (int i = 0; i < n; i++) begin
      wr(OFF_MADDR, {24'h0, a + 8'(i)});
      wr(OFF_MDATA, {16'h0, v[16*i +: 16]});
    end
  endtask : mw

  task automatic mck(input logic [7:0] a, input logic [31:0] e, input int n);
    for (int i = 0; i < n; i++) begin
      wr(OFF_MADDR, {24'h0, a + 8'(i)});
      repeat (2) @(posedge aclk);
      rck(OFF_MDATA, {16'h0, e[16*i +: 16]}, RESP_OKAY);
    end
  endtask : mck

  task automatic fl(input logic [2:0] e);
    chk("flags", {29'h0, e}, {29'h0, fault_flag, zero_flag, msb_flag});
  endtask : fl

  task automatic go(input logic [3:0] op, input logic [15:0] s, input logic [7:0] d,
                    input logic [15:0] p, input logic [31:0] x);
    int k;
    wr(OFF_SRC, {16'h0, s});
    wr(OFF_DST, {24'h0, d});
    wr(OFF_PARAM, {16'h0, p});
    k = n_done;
    wr(OFF_CTRL, x | {20'h0, op, 8'h01});
    t0 = cyc;
    for (int i = 0; i < 400 && n_done == k; i++) @(posedge aclk);
    if ((x & CND) != 32'h0) chk("op done", 32'h1, {31'h0, n_done != k});
  endtask : go

  // ==========
  // scenarios
  task automatic t_bus;
    logic [1:0] r;
    fl(3'b000);
    rck(OFF_STATUS, 32'h0, RESP_OKAY);
    rck(12'h030, 32'h0, RESP_SLVERR);
    i_wmx_seq_model.wr(12'h030, 32'h1, r);
    chk("unmapped write", {30'h0, RESP_SLVERR}, {30'h0, r});
  endtask : t_bus

  task automatic t_copy;
    int tp;
    int k;
    mw(8'h10, 32'h8000, 1);
    go(OP_COPY, 16'h0010, 8'h20, 16'h0, CND);
    tp = t_done - t0;
    mck(8'h20, 32'h8000, 1);
    mck(8'h10, 32'h8000, 1);
    fl(3'b001);
    k = n_done;
    go(OP_INV, 16'h0010, 8'h20, 16'h0, 32'h0);
    chk("done count", 32'(k), 32'(n_done));
    mck(8'h20, 32'h8000, 1);
    go(OP_INV, 16'h0010, 8'h21, 16'h0, CND);
    mck(8'h21, 32'h7FFF, 1);
    fl(3'b000);
    wr(OFF_CONST, 32'h0000FFFF);
    go(OP_INV, 16'h0, 8'h22, 16'h0, CND | CST);
    mck(8'h22, 32'h0, 1);
    fl(3'b010);
    go(OP_FAST, 16'h0010, 8'h23, 16'h0, CND);
    mck(8'h23, 32'h8000, 1);
    fl(3'b010);
    chk("speed ratio", 32'h1, {31'h0, tp >= 10 * (t_done - t0)});
  endtask : t_copy

  task automatic t_pair;
    mw(8'h12, 32'h01F98700, 2);
    go(OP_PAIR, 16'h0012, 8'h30, 16'h0, CND);
    mck(8'h30, 32'h01F98700, 2);
    fl(3'b000);
    go(OP_INVP, 16'h0012, 8'h32, 16'h0, CND);
    mck(8'h32, 32'hFE0678FF, 2);
    fl(3'b001);
    wr(OFF_CONST, 32'hFFFFFFFF);
    go(OP_INVP, 16'h0, 8'h34, 16'h0, CND | CST);
    mck(8'h34, 32'h0, 2);
    fl(3'b010);
  endtask : t_pair

  task automatic t_swap;
    go(OP_SWAP, 16'h0010, 8'h12, 16'h0, CND);
    mck(8'h10, 32'h8700, 1);
    mck(8'h12, 32'h8000, 1);
    go(OP_SWAPP, 16'h0012, 8'h32, 16'h0, CND);
    mck(8'h12, 32'hFE0678FF, 2);
    mck(8'h32, 32'h01F98000, 2);
  endtask : t_swap

  task automatic t_index;
    go(OP_ADDR, 16'h0021, 8'h0, 16'h0, CND | 32'h1000);
    rck(OFF_INDEX + 12'h004, 32'h21, RESP_OKAY);
    chk("zero flag", 32'h0, {31'h0, zero_flag});
    go(OP_ADDR, 16'h0015, 8'h0, 16'h0, CND | TCN | 32'h2000);
    rck(OFF_INDEX + 12'h008, 32'h2015, RESP_OKAY);
    go(OP_ADDR, 16'h0, 8'h0, 16'h0, CND | 32'h3000);
    rck(OFF_INDEX + 12'h00C, 32'h0, RESP_OKAY);
    chk("zero flag", 32'h1, {31'h0, zero_flag});
  endtask : t_index

  task automatic t_ind;
    mw(8'h40, 32'h00A0, 1);
    go(OP_COPY, 16'h0040, 8'h41, 16'h0, CND | IND | DEC);
    chk("fault flag", 32'h1, {31'h0, fault_flag});
    mw(8'h40, 32'h0012, 1);
    mw(8'h0C, 32'h5A00, 1);
    go(OP_COPY, 16'h0040, 8'h41, 16'h0, CND | IND | DEC);
    mck(8'h41, 32'h5A00, 1);
    fl(3'b000);
  endtask : t_ind

  task automatic t_bits;
    mw(8'h50, 32'h1234ABCD, 2);
    go(OP_BITF, 16'h0050, 8'h51, 16'h0884, CND);
    mck(8'h51, 32'hBC34, 1);
    go(OP_BITF, 16'h0050, 8'h51, 16'h0084, CND);
    mck(8'h51, 32'hBC34, 1);
    mw(8'h52, 32'h1234ABCD, 2);
    mw(8'h54, 32'hFFFF0000, 2);
    go(OP_BITF, 16'h0052, 8'h54, 16'h08CC, CND);
    mck(8'h54, 32'hFFF4A000, 2);
    mck(8'h52, 32'h1234ABCD, 2);
  endtask : t_bits

  task automatic t_block;
    mw(8'h60, 32'h00020001, 2);
    mw(8'h62, 32'h0003, 1);
    mw(8'h72, 32'h55550000, 2);
    go(OP_BLOCK, 16'h0060, 8'h70, 16'h0003, CND);
    mck(8'h70, 32'h00020001, 2);
    mck(8'h72, 32'h55550003, 2);
  endtask : t_block

  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    t_bus();
    t_copy();
    t_pair();
    t_swap();
    t_index();
    t_ind();
    t_bits();
    t_block();
    stop_test();
  end
endmodule : tb_top
`default_nettype wire
